// >>> design/adc_seq_regs.svh
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_CHAN 8'h04
`define OFS_RESULT 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PORT 8'h10

// Mode register fields
`define MODE_RUN_BIT 7
`define MODE_SPEED_HI 5
`define MODE_SPEED_LO 3
`define MODE_CE_BIT 0

// Channel select field
`define CHAN_HI 1

// Status register fields
`define STAT_FLAG_BIT 0
`define STAT_SUSPECT_BIT 1
`define STAT_BUSY_BIT 2

// Reset values
`define MODE_RESET 8'h00
`define CHAN_RESET 2'h0

// Timing
`define CLK_MHZ 250
`define SETTLE_US 14
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)
`define BIT_CYCLES_BASE 4
`define SAMPLE_BIT_SLOTS 2

`endif

// >>> design/adc_seq_pkg.sv
package adc_seq_pkg;

    // Mode register contents
    typedef struct packed {
        logic run;
        logic [2:0] speed;
        logic ce;
    } mode_t;

    // Converter sequencing states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } sar_state_t;

endpackage

// >>> design/sar_core.sv
`timescale 1ns/10ps
`include "adc_seq_regs.svh"

module sar_core
    import adc_seq_pkg::*;
#(
    parameter int RES = 10
)
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic run, // Converter running
    input wire logic restart, // Abort and start over
    input wire logic [2:0] speed, // Conversion speed field
    input wire logic comp, // Synchronised comparator output
    output logic sampling, // Sampling phase active
    output logic busy, // Sampling or converting
    output logic [RES-1:0] dac_code, // Trial code to the DAC
    output logic done, // One-cycle end of conversion
    output logic [RES-1:0] result // Final code, valid with done
);

    generate
        if (RES < 2 || RES > 16)
        begin : g_check
            $error("sar_core: RES out of range");
        end
    endgenerate

    sar_state_t state, next_state;
    logic [11:0] cnt, next_cnt;
    logic [3:0] bit_idx, next_bit_idx;
    logic [RES-1:0] next_dac_code, next_result;
    logic next_done, next_sampling, next_busy;
    logic [11:0] bit_cycles;

    // Cycles per decided bit from the speed field
    function automatic logic [11:0] cycles_per_bit(input logic [2:0] sp);
        cycles_per_bit = 12'(`BIT_CYCLES_BASE) << sp;
    endfunction

    assign bit_cycles = cycles_per_bit(speed);

    // Sequencing: sample for two bit slots, then one slot per bit
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_bit_idx = bit_idx;
        next_dac_code = dac_code;
        next_result = result;
        next_done = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (run)
                begin
                    next_state = ST_SAMPLE;
                    next_cnt = 12'(`SAMPLE_BIT_SLOTS) * bit_cycles - 12'h001;
                end
            end
            ST_SAMPLE:
            begin
                if (cnt == 12'h000)
                begin
                    next_state = ST_CONVERT;
                    next_bit_idx = 4'(RES - 1);
                    next_dac_code = {1'b1, {(RES-1){1'b0}}};
                    next_cnt = bit_cycles - 12'h001;
                end
                else
                    next_cnt = cnt - 12'h001;
            end
            ST_CONVERT:
            begin
                if (cnt == 12'h000)
                begin
                    // Comparator low: trial too high, drop the bit
                    if (!comp)
                        next_dac_code[bit_idx] = 1'b0;
                    if (bit_idx == 4'h0)
                    begin
                        next_done = 1'b1;
                        next_result = next_dac_code;
                        next_state = ST_SAMPLE;
                        next_cnt = 12'(`SAMPLE_BIT_SLOTS) * bit_cycles - 12'h001;
                    end
                    else
                    begin
                        next_bit_idx = bit_idx - 4'h1;
                        next_dac_code[bit_idx - 4'h1] = 1'b1;
                        next_cnt = bit_cycles - 12'h001;
                    end
                end
                else
                    next_cnt = cnt - 12'h001;
            end
            default:
                next_state = ST_IDLE;
        endcase
        // Stop or a mode or channel write abandons the conversion
        if (!run || restart)
        begin
            next_state = ST_IDLE;
            next_done = 1'b0;
        end
        next_sampling = (next_state == ST_SAMPLE);
        next_busy = (next_state != ST_IDLE);
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= ST_IDLE;
            cnt <= 12'h000;
            bit_idx <= 4'h0;
            dac_code <= '0;
            result <= '0;
            done <= 1'b0;
            sampling <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            bit_idx <= next_bit_idx;
            dac_code <= next_dac_code;
            result <= next_result;
            done <= next_done;
            sampling <= next_sampling;
            busy <= next_busy;
        end
    end

endmodule

// >>> design/adc_sequencing_control.sv
`timescale 1ns/10ps
`include "adc_seq_regs.svh"

module adc_sequencing_control
    import adc_seq_pkg::*;
#(
    parameter int RES = 10,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
)
(
    input wire logic clk, // 250 MHz clock
    input wire logic srst, // Synchronous reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic comp_in, // Analog comparator output
    input wire logic [3:0] shared_port_pins, // Digital view of shared pins
    output logic [1:0] analog_mux_sel, // Selected analog input
    output logic comparator_power, // Comparator enable
    output logic sample_hold, // Sampling capacitor connected
    output logic [RES-1:0] dac_code, // Trial code to the DAC
    output logic [3:0] port_input_en, // Digital input buffers on
    output logic conversion_end_irq // One-cycle end of conversion
);

    generate
        if (RES != 10)
        begin : g_res_check
            $error("adc_sequencing_control: only 10-bit results are served");
        end
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
        begin : g_settle_check
            $error("adc_sequencing_control: SETTLE_CYCLES out of range");
        end
    endgenerate

    mode_t mode, next_mode;
    logic [1:0] next_chan;
    logic [RES-1:0] result, next_result;
    logic flag, next_flag;
    logic first_unsafe, next_first_unsafe;
    logic suspect, next_suspect;
    logic [15:0] settle_cnt, next_settle_cnt;
    logic [31:0] next_rdata;
    logic next_ack, next_irq;
    logic [3:0] next_port_en;
    logic comp_meta, comp_sync;
    logic [3:0] pins_meta, pins_sync;
    logic core_sampling, core_busy, core_done;
    logic [RES-1:0] core_result;
    logic access, wr, wr_mode, wr_chan, wr_stat, restart, store, settled;

    // Two-flop synchronisers for outside signals
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            pins_meta <= 4'h0;
            pins_sync <= 4'h0;
        end
        else
        begin
            comp_meta <= comp_in;
            comp_sync <= comp_meta;
            pins_meta <= shared_port_pins;
            pins_sync <= pins_meta;
        end
    end

    // Successive-approximation sequencer
    sar_core #(
        .RES(RES)
    ) u_core (
        .clk(clk),
        .srst(srst),
        .run(mode.run),
        .restart(restart),
        .speed(mode.speed),
        .comp(comp_sync),
        .sampling(core_sampling),
        .busy(core_busy),
        .dac_code(dac_code),
        .done(core_done),
        .result(core_result)
    );

    // Bus decode, taken once per request
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign wr_mode = wr && (wb_adr_i == `OFS_MODE);
    assign wr_chan = wr && (wb_adr_i == `OFS_CHAN);
    assign wr_stat = wr && (wb_adr_i == `OFS_STATUS);
    assign restart = wr_mode || wr_chan;
    assign store = core_done && !restart;
    assign settled = (settle_cnt == 16'(SETTLE_CYCLES));

    // Register and status next values
    always_comb
    begin
        next_mode = mode;
        next_chan = analog_mux_sel;
        next_result = result;
        next_flag = flag;
        next_first_unsafe = first_unsafe;
        next_suspect = suspect;
        next_settle_cnt = settle_cnt;
        next_rdata = 32'h0000_0000;
        next_ack = access;
        next_irq = store;
        // Settling time after comparator enable
        if (!mode.ce)
            next_settle_cnt = 16'h0000;
        else if (!settled)
            next_settle_cnt = settle_cnt + 16'h0001;
        if (wr_mode)
        begin
            next_mode.run = wb_dat_i[`MODE_RUN_BIT];
            next_mode.speed = wb_dat_i[`MODE_SPEED_HI:`MODE_SPEED_LO];
            next_mode.ce = wb_dat_i[`MODE_CE_BIT];
            // Start too early or without the comparator
            if (wb_dat_i[`MODE_RUN_BIT] && !mode.run)
                next_first_unsafe = !(settled && wb_dat_i[`MODE_CE_BIT]);
        end
        if (wr_chan)
            next_chan = wb_dat_i[`CHAN_HI:0];
        // Clear by writing one; a new result wins
        if (wr_stat && wb_dat_i[`STAT_FLAG_BIT])
            next_flag = 1'b0;
        if (store)
        begin
            next_result = core_result;
            next_flag = 1'b1;
            next_suspect = first_unsafe;
            next_first_unsafe = 1'b0;
        end
        // Read data sampled before this edge's result update
        if (access && !wb_we_i)
        begin
            case (wb_adr_i)
                `OFS_MODE:
                begin
                    next_rdata[`MODE_RUN_BIT] = mode.run;
                    next_rdata[`MODE_SPEED_HI:`MODE_SPEED_LO] = mode.speed;
                    next_rdata[`MODE_CE_BIT] = mode.ce;
                end
                `OFS_CHAN:
                    next_rdata[`CHAN_HI:0] = analog_mux_sel;
                `OFS_RESULT:
                    next_rdata[RES-1:0] = result;
                `OFS_STATUS:
                begin
                    next_rdata[`STAT_FLAG_BIT] = flag;
                    next_rdata[`STAT_SUSPECT_BIT] = suspect;
                    next_rdata[`STAT_BUSY_BIT] = core_busy;
                end
                `OFS_PORT:
                    next_rdata[3:0] = pins_sync;
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
        // Selected pin's digital buffer off while converting
        next_port_en = 4'hf;
        if (core_busy)
            next_port_en[analog_mux_sel] = 1'b0;
    end

    // Register file and output flops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode <= mode_t'(5'h00);
            analog_mux_sel <= `CHAN_RESET;
            result <= '0;
            flag <= 1'b0;
            first_unsafe <= 1'b0;
            suspect <= 1'b0;
            settle_cnt <= 16'h0000;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            conversion_end_irq <= 1'b0;
            comparator_power <= 1'b0;
            sample_hold <= 1'b0;
            port_input_en <= 4'hf;
        end
        else
        begin
            mode <= next_mode;
            analog_mux_sel <= next_chan;
            result <= next_result;
            flag <= next_flag;
            first_unsafe <= next_first_unsafe;
            suspect <= next_suspect;
            settle_cnt <= next_settle_cnt;
            wb_dat_o <= next_rdata;
            wb_ack_o <= next_ack;
            conversion_end_irq <= next_irq;
            comparator_power <= next_mode.ce;
            sample_hold <= core_sampling;
            port_input_en <= next_port_en;
        end
    end

endmodule

// >>> testbench/analog_source_model.sv
`timescale 1ns/10ps
module analog_source_model
(
    input wire logic [39:0] levels, // Four 10-bit input levels
    input wire logic [3:0] pin_bits, // Digital pin levels
    input wire logic [1:0] analog_mux_sel, // Selected channel
    input wire logic [9:0] dac_code, // Trial code
    output logic comp_in, // Comparator result
    output logic [3:0] shared_port_pins // Pin levels seen by port
);
    // Selected input against trial code
    assign comp_in = (levels[analog_mux_sel*10 +: 10] >= dac_code);
    // Same pins double as a digital port
    assign shared_port_pins = pin_bits;
endmodule

// >>> testbench/adc_seq_asserts.sv
`timescale 1ns/10ps
module adc_seq_asserts
    import adc_seq_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [7:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Lanes
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic [1:0] analog_mux_sel, // Channel
    input wire logic comparator_power, // Comparator on
    input wire logic sample_hold, // Sampling
    input wire logic [3:0] port_input_en, // Buffers on
    input wire logic conversion_end_irq // End pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Accepted request and accepted write
    wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire wr = take & wb_we_i & wb_sel_i[0];
    wire wr_ctl = wr & (wb_adr_i == 8'h00 || wb_adr_i == 8'h04);
    // Sampling run length, and whether a control write cut it short
    logic [11:0] hold_len;
    logic cut;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hold_len <= 12'h000;
            cut <= 1'b0;
        end
        else
        begin
            if (!sample_hold)
                hold_len <= 12'h000;
            else if (hold_len != 12'hfff)
                hold_len <= hold_len + 12'h001;
            if (wr_ctl)
                cut <= 1'b1;
            else if (!sample_hold)
                cut <= 1'b0;
        end
    end
    property p_ack; take |=> wb_ack_o; endproperty
    property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_ce; wr && wb_adr_i == 8'h00 |=> comparator_power == $past(wb_dat_i[0]); endproperty
    property p_chan; wr && wb_adr_i == 8'h04 |=> analog_mux_sel == $past(wb_dat_i[1:0]);
    endproperty
    property p_chan_hold; !(wr && wb_adr_i == 8'h04) |=> $stable(analog_mux_sel); endproperty
    property p_irq; conversion_end_irq |=> !conversion_end_irq; endproperty
    property p_sample;
        $fell(sample_hold) && !cut |-> hold_len >= 12'h008 && hold_len <= 12'h400;
    endproperty
    property p_port;
        sample_hold && $past(sample_hold) && $stable(analog_mux_sel)
            |-> port_input_en[analog_mux_sel] == 1'b0;
    endproperty
    property p_restart; wr_ctl |=> (!conversion_end_irq)[*8]; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    a_ce: assert property (p_ce) else $error("comparator enable not written");
    a_chan: assert property (p_chan) else $error("channel not written");
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
    a_irq: assert property (p_irq) else $error("irq not a pulse");
    a_sample: assert property (p_sample) else $error("sampling too short");
    a_port: assert property (p_port) else $error("buffer on during sampling");
    a_restart: assert property (p_restart) else $error("irq after restart");
    c_irq: cover property (conversion_end_irq);
    c_sample: cover property ($rose(sample_hold));
    c_ctl: cover property (wr_ctl);
endmodule
bind adc_sequencing_control adc_seq_asserts u_adc_seq_asserts (.clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .analog_mux_sel, .comparator_power, .sample_hold, .port_input_en, .conversion_end_irq);

// >>> testbench/adc_sequencing_control_tb_top.sv
`timescale 1ns/10ps
module adc_sequencing_control_tb_top
    import adc_seq_pkg::*;
;
    localparam logic [39:0] LEVELS = {10'h3ff, 10'h200, 10'h155, 10'h000};
    // Rows: channel beside expected code
    localparam logic [11:0] ROWS [4] = '{{2'h1, 10'h155}, {2'h3, 10'h3ff},
        {2'h0, 10'h000}, {2'h2, 10'h200}};
    logic [39:0] levels = LEVELS;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    logic wb_ack_o, comp_in, comparator_power, sample_hold, conversion_end_irq;
    logic [3:0] shared_port_pins, port_input_en;
    logic [1:0] analog_mux_sel;
    logic [9:0] dac_code;
    int miscompares = 0, n_checks = 0, cycles = 0, n;
    always #2 clk = ~clk;
    adc_sequencing_control #(.RES(10), .SETTLE_CYCLES(20)) u_adc_sequencing_control (.clk,
        .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .comp_in, .shared_port_pins, .analog_mux_sel, .comparator_power,
        .sample_hold, .dac_code, .port_input_en, .conversion_end_irq);
    analog_source_model u_analog_source_model (.levels(levels), .pin_bits(4'ha),
        .analog_mux_sel, .dac_code, .comp_in, .shared_port_pins);
    // Verdict and end of run
    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            results();
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wait_irq;
        do @(posedge clk); while (conversion_end_irq !== 1'b1);
    endtask
    // Length of one full sampling phase
    task sample_len(output int len);
        while (sample_hold === 1'b1) @(posedge clk);
        do @(posedge clk); while (sample_hold !== 1'b1);
        len = 0;
        while (sample_hold === 1'b1)
        begin
            len++;
            @(posedge clk);
        end
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        cmp(port_input_en, 32'hf);
        for (int i = 0; i < 2; i++)
        begin
            wb(1'b0, 8'h00 + 8'(4 * i), 32'h0);
            cmp(rdata, 32'h0);
        end
        // Run together with comparator enable: early start
        wb(1'b1, 8'h00, 32'h81);
        wait_irq();
        wb(1'b0, 8'h0c, 32'h0);
        cmp(rdata & 32'h3, 32'h3);
        wb(1'b1, 8'h00, 32'h01);
        wb(1'b1, 8'h0c, 32'h1);
        repeat (30) @(posedge clk);
        wb(1'b0, 8'h10, 32'h0);
        cmp(rdata, 32'ha);
        wb(1'b1, 8'h00, 32'h81);
        foreach (ROWS[i])
        begin
            wb(1'b1, 8'h04, {30'h0, ROWS[i][11:10]});
            repeat (4) @(posedge clk);
            wait_irq();
            wb(1'b0, 8'h08, 32'h0);
            cmp(rdata, {22'h0, ROWS[i][9:0]});
        end
        wb(1'b0, 8'h0c, 32'h0);
        cmp(rdata & 32'h3, 32'h1);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        cmp(rdata & 32'h1, 32'h1);
        for (int s = 0; s < 3; s += 2)
        begin
            wb(1'b1, 8'h00, 32'h81 | (s << 3));
            sample_len(n);
            cmp(n, 32'(8 << s));
        end
        // Read, then channel write, landing on a conversion end (48 cycles apart)
        wb(1'b1, 8'h00, 32'h81);
        wait_irq();
        levels[9:0] <= 10'h0aa;
        repeat (45) @(posedge clk);
        wb(1'b0, 8'h08, 32'h0);
        cmp(rdata, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        cmp(rdata, 32'h0aa);
        wait_irq();
        levels[9:0] <= 10'h0cc;
        wb(1'b1, 8'h0c, 32'h1);
        repeat (42) @(posedge clk);
        wb(1'b1, 8'h04, 32'h0);
        repeat (20) @(posedge clk);
        wb(1'b0, 8'h0c, 32'h0);
        cmp(rdata & 32'h1, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        cmp(rdata, 32'h0aa);
        wb(1'b1, 8'h00, 32'h01);
        wb(1'b1, 8'h0c, 32'h1);
        repeat (200) @(posedge clk);
        wb(1'b0, 8'h0c, 32'h0);
        cmp(rdata & 32'h5, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        cmp(rdata, 32'h0);
        results();
    end
endmodule
